// File: pkg/ssw_pkg.sv
// How it works
// - mismatch makes device raise error_out_lines
// - supervisor watches error_out_lines as failure
// - device sends trigger on each software kick, except a kick given while a message is in flight
// - any failure drives device reset low
// - fail-safe output cuts external power switch
// - missed trigger within timeout forces safe state
// - safe state removes power and physical driver
// - trigger is transition or message, selected by trig_mode
// - trigger channel toggle line or serial link
// - once failed, stay safe until supervisor reset
// - both lines connected must agree, else failure
// - error lines synchronised and filtered, not gated
`default_nettype none
package ssw_pkg;
    localparam int unsigned CLK_NS        = 50;
    localparam int unsigned TIMEOUT_US    = 10000;
    localparam int unsigned TIMEOUT_CYC   = (TIMEOUT_US * 1000) / CLK_NS;
    localparam int unsigned RESET_US      = 100;
    localparam int unsigned RESET_CYC     = (RESET_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WD_CNT_W      = 18;
    localparam int unsigned RST_CNT_W     = 12;
    localparam logic [2:0]  MISMATCH_CYC  = 3'h4;
    localparam logic [1:0]  SCLK_HALF_CYC = 2'h2;
    localparam int unsigned MSG_BITS      = 8;
    localparam logic [7:0]  TRIG_KEY      = 8'h5a;
    localparam logic [2:0]  LAST_BIT      = 3'h7;

    typedef enum logic {
        TRIG_TOGGLE = 1'b0,
        TRIG_MSG    = 1'b1
    } ssw_trig_mode_e;

    typedef enum logic [2:0] {
        CAUSE_NONE    = 3'h0,
        CAUSE_ERR     = 3'h1,
        CAUSE_TIMEOUT = 3'h2,
        CAUSE_PATH    = 3'h3,
        CAUSE_BAD_MSG = 3'h4
    } ssw_cause_e;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_RESET = 2'h1,
        ST_SAFE  = 2'h2
    } ssw_sup_state_e;

    typedef enum logic {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } ssw_tx_state_e;
endpackage
`default_nettype wire

// File: pkg/ssw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssw_link_if;
    logic [1:0] err_out;   // error_out_lines, high = fault
    logic       trig_line; // toggled trigger line
    logic       sclk;      // serial trigger clock
    logic       mosi;      // serial trigger data
    logic       cs_n;      // serial frame select, low active
    logic       reset_n;   // reset to device, low active
    logic       power_en;  // fail-safe power switch enable
    logic       phy_en;    // physical layer driver enable

    modport dev (
        output err_out,
        output trig_line,
        output sclk,
        output mosi,
        output cs_n,
        input  reset_n
    );
    modport sup (
        input  err_out,
        input  trig_line,
        input  sclk,
        input  mosi,
        input  cs_n,
        output reset_n,
        output power_en,
        output phy_en
    );
endinterface
`default_nettype wire

// File: src/ssw_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_device_end
    import ssw_pkg::*;
(
    input  wire logic clk_sys,   // system clock
    input  wire logic rst,       // sync reset, high
    input  wire logic kick,      // software trigger request
    input  wire logic mismatch,  // redundancy_checker mismatch
    input  wire logic trig_mode, // 0 toggle, 1 message
    output logic      fault,     // fault latched
    output logic      busy,      // message in flight
    ssw_link_if.dev   link       // link to supervisor
);
    logic          fault_ff;
    logic          trig_ff;
    logic          sclk_ff;
    logic          mosi_ff;
    logic          cs_n_ff;
    logic [7:0]    shreg_ff;
    logic [2:0]    bit_ff;
    logic [1:0]    div_ff;
    ssw_tx_state_e tx_ff;

    // supervisor reset holds the device in reset too
    wire dev_rst   = rst | ~link.reset_n;
    wire tx_idle   = (tx_ff == TX_IDLE);
    wire start_msg = kick & tx_idle & (trig_mode == TRIG_MSG);
    wire half_done = (div_ff == SCLK_HALF_CYC - 2'h1);
    wire last_fall = half_done & sclk_ff & (bit_ff == LAST_BIT);

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            fault_ff <= 1'b0;
        end else if (mismatch) begin
            fault_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            trig_ff <= 1'b0;
        end else if (kick && trig_mode == TRIG_TOGGLE) begin
            trig_ff <= ~trig_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dev_rst) begin
            tx_ff    <= TX_IDLE;
            sclk_ff  <= 1'b0;
            mosi_ff  <= 1'b0;
            cs_n_ff  <= 1'b1;
            shreg_ff <= 8'h00;
            bit_ff   <= 3'h0;
            div_ff   <= 2'h0;
        end else if (start_msg) begin
            tx_ff    <= TX_SHIFT;
            cs_n_ff  <= 1'b0;
            mosi_ff  <= TRIG_KEY[7];
            shreg_ff <= {TRIG_KEY[6:0], 1'b0};
            bit_ff   <= 3'h0;
            div_ff   <= 2'h0;
        end else if (tx_ff == TX_SHIFT) begin
            div_ff <= half_done ? 2'h0 : div_ff + 2'h1;
            if (half_done) begin
                sclk_ff <= ~sclk_ff;
                if (last_fall) begin
                    tx_ff   <= TX_IDLE;
                    cs_n_ff <= 1'b1;
                end else if (sclk_ff) begin
                    bit_ff   <= bit_ff + 3'h1;
                    mosi_ff  <= shreg_ff[7];
                    shreg_ff <= {shreg_ff[6:0], 1'b0};
                end
            end
        end
    end

    assign link.err_out   = {fault_ff, fault_ff};
    assign link.trig_line = trig_ff;
    assign link.sclk      = sclk_ff;
    assign link.mosi      = mosi_ff;
    assign link.cs_n      = cs_n_ff;
    assign fault          = fault_ff;
    assign busy           = (tx_ff == TX_SHIFT);
endmodule
`default_nettype wire

// File: src/ssw_supervisor_end.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_end
    import ssw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input  wire logic  clk_sys,    // supervisor own clock
    input  wire logic  rst,        // sync reset, high
    input  wire logic  trig_mode,  // 0 toggle, 1 message
    input  wire logic  both_conn,  // both error lines wired
    output logic       safe_state, // safe state latched
    output logic [2:0] cause,      // first failure cause
    ssw_link_if.sup    link        // link to device
);
    logic [1:0]           err_s1_ff;
    logic [1:0]           err_s2_ff;
    logic [1:0]           err_s3_ff;
    logic [1:0]           err_f_ff;
    logic [2:0]           mis_cnt_ff;
    logic                 trig_q_ff;
    logic                 trig_q2_ff;
    logic                 sclk_q_ff;
    logic                 sclk_q2_ff;
    logic                 mosi_q_ff;
    logic                 cs_q_ff;
    logic                 cs_q2_ff;
    logic [7:0]           rx_ff;
    logic [3:0]           rx_cnt_ff;
    logic [WD_CNT_W-1:0]  wd_cnt_ff;
    logic [RST_CNT_W-1:0] rst_cnt_ff;
    ssw_sup_state_e       st_ff;
    logic                 reset_n_ff;
    logic                 power_ff;
    logic                 phy_ff;
    logic                 safe_ff;
    ssw_cause_e           cause_ff;

    // error lines: two-stage synchroniser, then two-sample agreement filter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_s1_ff <= 2'h0;
            err_s2_ff <= 2'h0;
            err_s3_ff <= 2'h0;
            err_f_ff  <= 2'h0;
        end else begin
            err_s1_ff <= link.err_out;
            err_s2_ff <= err_s1_ff;
            err_s3_ff <= err_s2_ff;
            err_f_ff  <= (err_s2_ff & err_s3_ff) | (err_f_ff & (err_s2_ff | err_s3_ff));
        end
    end

    wire err_seen  = both_conn ? |err_f_ff : err_f_ff[0];
    wire err_diff  = both_conn & (err_f_ff[0] ^ err_f_ff[1]);
    wire path_fail = (mis_cnt_ff == MISMATCH_CYC);

    always_ff @(posedge clk_sys) begin
        if (rst || !err_diff) begin
            mis_cnt_ff <= 3'h0;
        end else if (!path_fail) begin
            mis_cnt_ff <= mis_cnt_ff + 3'h1;
        end
    end

    // trigger inputs sampled on the supervisor clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_q_ff  <= 1'b0;
            trig_q2_ff <= 1'b0;
            sclk_q_ff  <= 1'b0;
            sclk_q2_ff <= 1'b0;
            mosi_q_ff  <= 1'b0;
            cs_q_ff    <= 1'b1;
            cs_q2_ff   <= 1'b1;
        end else begin
            trig_q_ff  <= link.trig_line;
            trig_q2_ff <= trig_q_ff;
            sclk_q_ff  <= link.sclk;
            sclk_q2_ff <= sclk_q_ff;
            mosi_q_ff  <= link.mosi;
            cs_q_ff    <= link.cs_n;
            cs_q2_ff   <= cs_q_ff;
        end
    end

    wire msg_mode  = (trig_mode == TRIG_MSG);
    wire sclk_rise = sclk_q_ff & ~sclk_q2_ff & ~cs_q_ff;
    wire frame_end = cs_q_ff & ~cs_q2_ff;
    wire frame_ok  = (rx_cnt_ff == 4'(MSG_BITS)) & (rx_ff == TRIG_KEY);
    wire tog_trig  = ~msg_mode & (trig_q_ff ^ trig_q2_ff);
    wire msg_trig  = msg_mode & frame_end & frame_ok;
    wire bad_msg   = msg_mode & frame_end & ~frame_ok;
    wire trig_ok   = tog_trig | msg_trig;

    always_ff @(posedge clk_sys) begin
        if (rst || frame_end) begin
            rx_ff     <= 8'h00;
            rx_cnt_ff <= 4'h0;
        end else if (sclk_rise) begin
            rx_ff     <= {rx_ff[6:0], mosi_q_ff};
            rx_cnt_ff <= (rx_cnt_ff == 4'hf) ? rx_cnt_ff : rx_cnt_ff + 4'h1;
        end
    end

    wire running  = (st_ff == ST_RUN);
    wire timeout  = (wd_cnt_ff == WD_CNT_W'(TIMEOUT_CYCLES - 1));
    wire rst_done = (rst_cnt_ff == RST_CNT_W'(RESET_CYC - 1));

    // timeout runs on the supervisor clock only
    always_ff @(posedge clk_sys) begin
        if (rst || !running || trig_ok) begin
            wd_cnt_ff <= '0;
        end else if (!timeout) begin
            wd_cnt_ff <= wd_cnt_ff + 1'b1;
        end
    end

    wire        fail = running & (err_seen | path_fail | timeout | bad_msg);
    ssw_cause_e nxt_cause;
    assign nxt_cause = err_seen  ? CAUSE_ERR :
                       path_fail ? CAUSE_PATH :
                       bad_msg   ? CAUSE_BAD_MSG :
                       timeout   ? CAUSE_TIMEOUT : CAUSE_NONE;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff      <= ST_RUN;
            reset_n_ff <= 1'b0;
            power_ff   <= 1'b0;
            phy_ff     <= 1'b0;
            safe_ff    <= 1'b0;
            cause_ff   <= CAUSE_NONE;
            rst_cnt_ff <= '0;
        end else begin
            unique case (st_ff)
                ST_RUN: begin
                    reset_n_ff <= 1'b1;
                    power_ff   <= 1'b1;
                    phy_ff     <= 1'b1;
                    if (fail) begin
                        st_ff      <= ST_RESET;
                        reset_n_ff <= 1'b0;
                        power_ff   <= 1'b0;
                        phy_ff     <= 1'b0;
                        safe_ff    <= 1'b1;
                        cause_ff   <= nxt_cause;
                        rst_cnt_ff <= '0;
                    end
                end
                ST_RESET: begin
                    rst_cnt_ff <= rst_cnt_ff + 1'b1;
                    if (rst_done) begin
                        st_ff      <= ST_SAFE;
                        reset_n_ff <= 1'b1;
                    end
                end
                ST_SAFE: begin
                    st_ff <= ST_SAFE;
                end
                default: begin
                    st_ff <= ST_SAFE;
                end
            endcase
        end
    end

    assign link.reset_n  = reset_n_ff;
    assign link.power_en = power_ff;
    assign link.phy_en   = phy_ff;
    assign safe_state    = safe_ff;
    assign cause         = cause_ff;
endmodule
`default_nettype wire

// File: tb/ssw_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_link_assertions
    import ssw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic       clk_sys,   // clock
    input wire logic       rst,       // reset
    input wire logic [1:0] err_out,   // error lines
    input wire logic       trig_line, // toggle
    input wire logic       sclk,      // serial clk
    input wire logic       mosi,      // serial data
    input wire logic       cs_n,      // frame
    input wire logic       reset_n,   // dev reset
    input wire logic       power_en,  // power
    input wire logic       phy_en     // phy
);
    localparam int QUIET_MAX = TIMEOUT_CYCLES + 8;
    logic [11:0] low_ff;
    logic [17:0] quiet_ff;
    logic [3:0]  bits_ff;
    logic [7:0]  shf_ff;
    logic        sclk_ff;
    logic        trig_ff;
    logic        cs_ff;
    wire         sclk_rise = sclk & ~sclk_ff;
    wire         trig_seen = (trig_line ^ trig_ff) | (cs_n & ~cs_ff);
    wire  [11:0] nxt_low   = (rst | reset_n) ? 12'h0 : low_ff + 12'h1;
    wire  [17:0] nxt_quiet = (rst | ~power_en | trig_seen) ? 18'h0 : quiet_ff + 18'h1;
    wire  [3:0]  nxt_bits  = cs_n ? 4'h0 : bits_ff + {3'h0, sclk_rise};
    wire  [7:0]  nxt_shf   = sclk_rise ? {shf_ff[6:0], mosi} : shf_ff;

    always_ff @(posedge clk_sys) begin
        low_ff   <= nxt_low;
        quiet_ff <= nxt_quiet;
        bits_ff  <= nxt_bits;
        shf_ff   <= nxt_shf;
        sclk_ff  <= sclk;
        trig_ff  <= trig_line;
        cs_ff    <= cs_n;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_frame_end;
        reset_n && cs_n && !cs_ff;
    endsequence
    sequence s_err_rise;
        $rose(err_out[0]) && power_en;
    endsequence

    a_err_pair: assert property (err_out[0] == err_out[1])
        else $error("error lines differ");
    a_frame_ok: assert property (s_frame_end |-> bits_ff == 4'h8 && shf_ff == TRIG_KEY)
        else $error("bad trigger frame");
    a_err_held: assert property (err_out == 2'h3 && reset_n |=> err_out == 2'h3)
        else $error("error dropped");
    a_dev_cleared: assert property (!reset_n |=> err_out == 2'h0 && cs_n && !sclk)
        else $error("device not reset");
    a_err_react: assert property (s_err_rise |-> ##[1:8] !reset_n)
        else $error("error ignored");
    a_safe_pair: assert property (power_en == phy_en)
        else $error("power and phy differ");
    a_safe_kept: assert property ($fell(power_en) |=> !power_en [*8])
        else $error("safe state left");
    a_reset_len: assert property ($rose(reset_n) && !power_en |-> low_ff == RESET_CYC)
        else $error("reset pulse length");
    a_quiet_limit: assert property (power_en |-> quiet_ff < QUIET_MAX)
        else $error("missed timeout");
    a_sclk_framed: assert property (sclk |-> !cs_n)
        else $error("clock outside frame");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ssw_pkg::*;
;
    localparam int TMO = 64;
    logic       clk_sys    = 1'b0;
    logic       rst        = 1'b1;
    logic       kick       = 1'b0;
    logic       mismatch   = 1'b0;
    logic       trig_mode  = 1'b0;
    logic       both_conn  = 1'b1;
    logic       fault;
    logic       busy;
    logic       safe_state;
    logic [2:0] cause;
    logic [7:0] rx;
    logic       old;
    int         fail_count = 0;
    int         n_compared = 0;

    ssw_link_if link();
    ssw_device_end ssw_device_end_i(.clk_sys(clk_sys), .rst(rst), .kick(kick),
        .mismatch(mismatch), .trig_mode(trig_mode), .fault(fault), .busy(busy), .link(link.dev));
    ssw_supervisor_end #(.TIMEOUT_CYCLES(TMO)) ssw_supervisor_end_i(.clk_sys(clk_sys),
        .rst(rst), .trig_mode(trig_mode), .both_conn(both_conn), .safe_state(safe_state),
        .cause(cause), .link(link.sup));
    ssw_link_assertions #(.TIMEOUT_CYCLES(TMO)) ssw_link_assertions_i(.clk_sys(clk_sys),
        .rst(rst), .err_out(link.err_out), .trig_line(link.trig_line), .sclk(link.sclk),
        .mosi(link.mosi), .cs_n(link.cs_n), .reset_n(link.reset_n),
        .power_en(link.power_en), .phy_en(link.phy_en));

    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ran_out();
        fail_count++;
        $display("Error at %0t: wait ran out", $time);
        close_out();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic restart(input logic mode, input logic both);
        @(posedge clk_sys);
        rst <= 1'b1;
        trig_mode <= mode;
        both_conn <= both;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        tick(2);
    endtask

    task automatic give_kick();
        @(posedge clk_sys);
        kick <= 1'b1;
        @(posedge clk_sys);
        kick <= 1'b0;
        #1;
    endtask

    task automatic wait_power_off(input int n);
        int i;
        for (i = 0; i < n && link.power_en !== 1'b0; i++) tick(1);
        if (i == n) ran_out();
    endtask

    // shift in data at each serial clock rise until the frame ends
    task automatic send_msg(output logic [7:0] got);
        int   i;
        logic s;
        got = 8'h00;
        s = 1'b0;
        give_kick();
        chk({7'h0, busy}, 8'h01);
        // a kick while the frame is in flight must be ignored
        give_kick();
        for (i = 0; i < 60 && busy === 1'b1; i++) begin
            if (link.sclk === 1'b1 && s === 1'b0) got = {got[6:0], link.mosi};
            s = link.sclk;
            tick(1);
        end
        if (i == 60) ran_out();
    endtask

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        ran_out();
    end

    initial begin
        restart(1'b0, 1'b1);
        repeat (8) begin
            old = link.trig_line;
            give_kick();
            chk({7'h0, link.trig_line}, {7'h0, ~old});
            tick(20);
        end
        chk({7'h0, link.power_en}, 8'h01);
        chk({5'h0, cause}, 8'h00);
        restart(1'b1, 1'b1);
        repeat (4) begin
            send_msg(rx);
            chk(rx, TRIG_KEY);
            tick(10);
        end
        chk({7'h0, link.power_en}, 8'h01);
        // no more triggers: supervisor must time out
        wait_power_off(TMO + 20);
        chk({5'h0, cause}, {5'h0, CAUSE_TIMEOUT});
        chk({6'h0, link.reset_n, link.phy_en}, 8'h00);
        chk({7'h0, safe_state}, 8'h01);
        tick(RESET_CYC + 5);
        chk({6'h0, link.reset_n, link.power_en}, 8'h02);
        for (int b = 0; b < 2; b++) begin
            restart(1'b0, b[0]);
            give_kick();
            @(posedge clk_sys);
            mismatch <= 1'b1;
            @(posedge clk_sys);
            mismatch <= 1'b0;
            tick(1);
            chk({6'h0, link.err_out}, 8'h03);
            chk({7'h0, fault}, 8'h01);
            wait_power_off(12);
            chk({5'h0, cause}, {5'h0, CAUSE_ERR});
            chk({7'h0, link.reset_n}, 8'h00);
        end
        close_out();
    end
endmodule
`default_nettype wire
